// File: rtl/rss_regs.svh
// Purpose: timing constants for the reset source sequencer
// Assumes: mclk at 10 MHz, period 100 ns
// Notes:   times in their printed units, counts derived from them
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH
// =====================================================
// clock and times
`define RSS_CLK_HZ            10000000
`define RSS_POR_HOLD_US       4600
`define RSS_LVD_HOLD_US       4600
`define RSS_STARTUP_MIN_MS    570
`define RSS_STARTUP_MAX_MS    780
// =====================================================
// derived cycle counts (start-up from the maximum time)
`define RSS_POR_HOLD_CYC      ((`RSS_POR_HOLD_US * (`RSS_CLK_HZ / 1000000)))
`define RSS_LVD_HOLD_CYC      ((`RSS_LVD_HOLD_US * (`RSS_CLK_HZ / 1000000)))
`define RSS_STARTUP_CYC       ((`RSS_STARTUP_MAX_MS * (`RSS_CLK_HZ / 1000)))
`define RSS_CNT_W             23
`endif

// File: rtl/rss_pkg.sv
// Purpose: types for the reset source sequencer
// Assumes: nothing
// Notes:   one-hot sequencer states
package rss_pkg;
    // =====================================================
    // sequencer states
    typedef enum logic [2:0] {
        RSS_RESET = 3'h1,
        RSS_START = 3'h2,
        RSS_READY = 3'h4
    } rss_state_t;
    // =====================================================
    // status carried out of the block
    typedef struct packed {
        logic reset_n;
        logic ready;
    } rss_status_t;
endpackage

// File: rtl/rss_top.sv
// Purpose: merge pin, power-up and low-voltage resets into one internal reset
// Assumes: detector outputs and pin are asynchronous and synchronised here
// Notes:   hold and start-up counts are parameters for fast simulation
`timescale 1ns/10ps
`include "rss_regs.svh"
// Contract
// - any of three sources asserts reset
// - pin low holds device in reset
// - power-up reset needs pin held high
// - hold reset 4.6 ms after power-up
// - low-voltage detection enters reset
// - hold reset 4.6 ms after low-voltage clears
// - ready only after long start-up interval
// - all timing from main clock
// - sub-clock input ignored entirely
module rss_top
    import rss_pkg::*;
#(
    parameter logic [`RSS_CNT_W-1:0] POR_HOLD_CYC = `RSS_CNT_W'(`RSS_POR_HOLD_CYC),
    parameter logic [`RSS_CNT_W-1:0] LVD_HOLD_CYC = `RSS_CNT_W'(`RSS_LVD_HOLD_CYC),
    parameter logic [`RSS_CNT_W-1:0] STARTUP_CYC  = `RSS_CNT_W'(`RSS_STARTUP_CYC)
) (
    // clock and reset
    input  wire logic  mclk,
    input  wire logic  rst_n,
    // reset sources
    input  wire logic  ext_reset_n_pin,
    input  wire logic  power_up_below,
    input  wire logic  low_voltage_reset0,
    // unused sub-clock oscillator
    input  wire logic  sub_osc_in,
    // results
    output logic       int_reset_n,
    output logic       ctrl_ready
);
    // =====================================================
    // synchronisers
    logic [1:0]        pin_sync_reg;
    logic [1:0]        por_sync_reg;
    logic [1:0]        lvd_sync_reg;
    logic [`RSS_CNT_W-1:0] por_cnt_reg;
    logic [`RSS_CNT_W-1:0] lvd_cnt_reg;
    logic [`RSS_CNT_W-1:0] start_cnt_reg;
    logic              hold_active;
    logic              src_active;
    rss_state_t        state_reg;

    // detectors are analog, so each passes two flops first
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pin_sync_reg <= 2'h0;
            por_sync_reg <= 2'h3;
            lvd_sync_reg <= 2'h0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[0], ext_reset_n_pin};
            por_sync_reg <= {por_sync_reg[0], power_up_below};
            lvd_sync_reg <= {lvd_sync_reg[0], low_voltage_reset0};
        end
    end

    // sub_osc_in is deliberately left unread

    // any live source requests reset
    assign src_active = !pin_sync_reg[1] || por_sync_reg[1] || lvd_sync_reg[1];

    // =====================================================
    // hold counters restart on each new request
    // power-up hold only runs while pin is high
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            por_cnt_reg <= POR_HOLD_CYC;
        end else if (por_sync_reg[1]) begin
            por_cnt_reg <= POR_HOLD_CYC;
        end else if (por_cnt_reg != '0 && pin_sync_reg[1]) begin
            por_cnt_reg <= por_cnt_reg - 1'b1;
        end
    end

    // low-voltage hold counts down once detector clears
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lvd_cnt_reg <= '0;
        end else if (lvd_sync_reg[1]) begin
            lvd_cnt_reg <= LVD_HOLD_CYC;
        end else if (lvd_cnt_reg != '0) begin
            lvd_cnt_reg <= lvd_cnt_reg - 1'b1;
        end
    end

    assign hold_active = (por_cnt_reg != '0) || (lvd_cnt_reg != '0);

    // =====================================================
    // release and start-up sequence
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg     <= RSS_RESET;
            start_cnt_reg <= '0;
        end else if (src_active || hold_active) begin
            state_reg     <= RSS_RESET;
            start_cnt_reg <= STARTUP_CYC;
        end else begin
            case (state_reg)
                RSS_RESET: begin
                    state_reg <= RSS_START;
                end
                RSS_START: begin
                    if (start_cnt_reg <= `RSS_CNT_W'(1)) begin
                        state_reg <= RSS_READY;
                    end
                    start_cnt_reg <= start_cnt_reg - 1'b1;
                end
                RSS_READY: begin
                    state_reg <= RSS_READY;
                end
                default: begin
                    state_reg <= RSS_RESET;
                end
            endcase
        end
    end

    // outputs registered; the pin minimum widths are the driver's duty
    // is not checked here, a short pulse still resets
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            int_reset_n <= 1'b0;
            ctrl_ready  <= 1'b0;
        end else begin
            int_reset_n <= !(src_active || hold_active);
            ctrl_ready  <= (state_reg == RSS_READY) && !src_active && !hold_active;
        end
    end
endmodule

// File: dv/rss_top_assertions.sv
// Purpose: port checks of rss_top. Assumes: one clock. Notes: counters stand in for long holds
`timescale 1ns/10ps
module rss_chk #(parameter int POR_HOLD_CYC = 20, LVD_HOLD_CYC = 20, STARTUP_CYC = 50) (
    input wire logic mclk, rst_n, ext_reset_n_pin, power_up_below, low_voltage_reset0, sub_osc_in,
    input wire logic int_reset_n, ctrl_ready);
    logic [31:0] quiet, up, por_q, lvd_q;
    wire src = !ext_reset_n_pin || power_up_below || low_voltage_reset0;
    // quiet time since the last request keeps a released reset from dropping again
    always_ff @(posedge mclk) quiet <= (!rst_n || src) ? 32'h0 : quiet + 32'h1;
    always_ff @(posedge mclk) up <= (!rst_n || !int_reset_n) ? 32'h0 : up + 32'h1;
    // pin reset has no hold, so each detector keeps its own quiet count
    always_ff @(posedge mclk) por_q <= (!rst_n || power_up_below) ? 32'h0 : por_q + 32'h1;
    always_ff @(posedge mclk) lvd_q <= (!rst_n || low_voltage_reset0) ? 32'h0 : lvd_q + 32'h1;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_pin_reset: assert property (!ext_reset_n_pin |-> ##[1:3] !int_reset_n) else $error("pin low kept running");
    a_por_reset: assert property (power_up_below |-> ##[1:3] !int_reset_n) else $error("power-up kept running");
    a_lvd_reset: assert property (low_voltage_reset0 |-> ##[1:3] !int_reset_n) else $error("low supply kept running");
    a_lvd_hold: assert property ($fell(low_voltage_reset0) |-> !int_reset_n [*8]) else $error("hold cut short");
    a_release_floor: assert property ($rose(int_reset_n) |-> por_q >= POR_HOLD_CYC && lvd_q >= LVD_HOLD_CYC)
        else $error("early release");
    a_stay_up: assert property (int_reset_n && quiet >= 4 |=> int_reset_n) else $error("spurious reset");
    a_ready_early: assert property ($rose(ctrl_ready) |-> up >= STARTUP_CYC) else $error("ready too soon");
    a_ready_late: assert property (up == STARTUP_CYC + 8 |-> ctrl_ready) else $error("ready too late");
    c_release: cover property ($rose(int_reset_n));
    c_ready: cover property ($rose(ctrl_ready));
    c_lvd: cover property ($fell(low_voltage_reset0));
endmodule
bind rss_top rss_chk #(.POR_HOLD_CYC(POR_HOLD_CYC), .LVD_HOLD_CYC(LVD_HOLD_CYC), .STARTUP_CYC(STARTUP_CYC)) u_chk (.*);

// File: dv/rss_src_model.sv
// Purpose: pin driver and supply detectors. Assumes: bench requests. Notes: one clock of delay
`timescale 1ns/10ps
module rss_src_model (input wire logic mclk, input wire logic [2:0] req,
    output logic ext_reset_n_pin = 1'b1, output logic power_up_below = 1'b0, output logic low_voltage_reset0 = 1'b0);
    // pin idles high as through its pull-up; bench keeps each pulse long enough
    always_ff @(posedge mclk) begin
        ext_reset_n_pin <= !req[0];
        power_up_below <= req[1];
        low_voltage_reset0 <= req[2];
    end
endmodule

// File: dv/tb.sv
// Purpose: self-checking bench of rss_top. Assumes: short holds. Notes: checks away from edges
`timescale 1ns/10ps
module tb;
    localparam int H = 20, S = 50;
    logic mclk = 0, rst_n = 0, sub_osc_in = 0, pin, por, lvd, irn, rdy;
    logic [2:0] req = 3'h0;
    int errors = 0, n_tests = 0, cyc = 0, srcs[$] = {0, 1, 2};
    always #50 mclk = ~mclk;
    rss_src_model u_rss_src_model (.mclk(mclk), .req(req), .ext_reset_n_pin(pin), .power_up_below(por),
        .low_voltage_reset0(lvd));
    rss_top #(.POR_HOLD_CYC(23'(H)), .LVD_HOLD_CYC(23'(H)), .STARTUP_CYC(23'(S))) u_rss_top (.mclk(mclk),
        .rst_n(rst_n), .ext_reset_n_pin(pin), .power_up_below(por), .low_voltage_reset0(lvd),
        .sub_osc_in(sub_osc_in), .int_reset_n(irn), .ctrl_ready(rdy));
    // noise on the unused oscillator input must never matter
    always @(posedge mclk) sub_osc_in <= 1'($urandom);
    task conclude;
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge mclk) if (++cyc == 2000) begin errors++; conclude; end
    // compare at the falling edge where outputs are settled, then realign to the rising edge
    task chk(input logic [1:0] e, input string m);
        @(negedge mclk);
        n_tests++;
        if ({irn, rdy} !== e) begin errors++; $display("[FAIL] %0t %s", $time, m); end
        @(posedge mclk);
    endtask
    task wt(input int n); repeat (n) @(posedge mclk); endtask
    // pin has no hold of its own; a repeat request restarts the detector hold
    task pulse(input int s, input bit again);
        int h;
        h = (s == 0) ? 0 : H;
        req <= 3'(1 << s);
        wt($urandom_range(30, 6)); chk(2'b00, "source ignored");
        req <= 3'h0;
        if (again) begin wt(H / 2); req <= 3'(1 << s); wt(4); req <= 3'h0; end
        if (h > 0) begin wt(h - 2); chk(2'b00, "hold cut short"); end
        wt(10); chk(2'b10, "no release");
        wt(S + 8); chk(2'b11, "not ready");
        $display("test done source %0d", s);
    endtask
    initial begin
        void'($urandom(43246));
        wt(10); rst_n <= 1'b1;
        wt(H - 2); chk(2'b00, "power-up hold");
        wt(10); chk(2'b10, "power-up release");
        wt(S + 8); chk(2'b11, "start-up");
        $display("test done power-up");
        foreach (srcs[i]) pulse(srcs[i], 1'b0);
        pulse(2, 1'b1);
        conclude;
    end
endmodule
